// *** rtl/bod_core.sv ***
// decode and execute core for byte-oriented file register instructions
// assumes a fetch path presenting instr_i in Q1 and a data file with
// one-cycle read latency (data valid in Q3) and writes taken at end of Q4
//
// Chosen here: the register addresses and the Avalon-MM register port.
`include "bod_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module bod_core (
    input  wire logic                 core_clk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic [15:0]          instr_i,
    output var  bod_pkg::bod_q_t      q_phase_o,
    output logic      [15:0]          pc_o,
    output logic      [7:0]           file_raddr_o,
    output logic                      file_rd_o,
    input  wire logic [7:0]           file_rdata_i,
    output var  bod_pkg::bod_file_wr_t file_wr_o,
    input  wire logic [7:0]           hw_evt_i,
    input  wire logic [4:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    input  wire logic [3:0]           avs_byteenable_i,
    output logic      [31:0]          avs_readdata_o,
    output logic                      avs_waitrequest_o
);
    import bod_pkg::*;

    logic [15:0] ir;
    logic [7:0]  acc;
    logic [7:0]  flags;
    logic [7:0]  latch;
    logic [7:0]  evt;
    logic [7:0]  evt_pend;
    logic [15:0] prod;
    logic        run;
    logic        skip_pend;
    logic [7:0]  opnd;
    logic [7:0]  next_flags;
    logic [31:0] rd_mux;
    logic        sw_we;
    logic        wr_pcl;
    logic        wr_alu;
    logic        wr_accf;
    bod_exec_t   ex;
    bod_exec_t   ex_now;

    // 8-bit adder giving {ov, dc, c, sum}
    function automatic logic [10:0] add8(input logic [7:0] x,
                                         input logic [7:0] y,
                                         input logic       ci);
        logic [4:0] lo;
        logic [8:0] s;
        lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
        s  = {1'b0, x} + {1'b0, y} + {8'h00, ci};
        return {(x[7] == y[7]) && (s[7] != x[7]), lo[4], s[8], s[7:0]};
    endfunction

    // decode and process one instruction on operand f and accumulator a
    function automatic bod_exec_t exec_op(input logic [15:0] op,
                                          input logic [7:0]  f,
                                          input logic [7:0]  a,
                                          input logic [7:0]  fl);
        bod_exec_t  e;
        logic [10:0] ar;
        logic        arith;
        logic [8:0]  s1;
        logic [8:0]  s2;
        logic [7:0]  bm;
        e     = '0;
        ar    = '0;
        arith = 1'b0;
        s1    = '0;
        s2    = '0;
        bm    = 8'h01 << op[10:8];
        e.wf  = op[8];
        e.wa  = ~op[8];
        case (op[15:9])
            `BOD_OP_ADD: begin
                ar    = add8(a, f, 1'b0);
                arith = 1'b1;
            end
            `BOD_OP_ADDC: begin
                ar    = add8(a, f, fl[`BOD_FLAG_C]);
                arith = 1'b1;
            end
            `BOD_OP_SUB: begin
                ar    = add8(f, ~a, 1'b1);
                arith = 1'b1;
            end
            `BOD_OP_SUBB: begin
                ar    = add8(f, ~a, fl[`BOD_FLAG_C]);
                arith = 1'b1;
            end
            `BOD_OP_AND: begin
                e.res              = a & f;
                e.fmask[`BOD_FLAG_Z] = 1'b1;
            end
            `BOD_OP_OR: begin
                e.res              = a | f;
                e.fmask[`BOD_FLAG_Z] = 1'b1;
            end
            `BOD_OP_INV: begin
                e.res              = ~f;
                e.fmask[`BOD_FLAG_Z] = 1'b1;
            end
            `BOD_OP_DECSZ: begin
                e.res  = f - 8'h01;
                e.skip = (e.res == 8'h00);
            end
            `BOD_OP_INCSZ: begin
                e.res  = f + 8'h01;
                e.skip = (e.res == 8'h00);
            end
            `BOD_OP_DECSNZ: begin
                e.res  = f - 8'h01;
                e.skip = (e.res != 8'h00);
            end
            `BOD_OP_INCSNZ: begin
                e.res  = f + 8'h01;
                e.skip = (e.res != 8'h00);
            end
            `BOD_OP_RLC: begin
                e.res                = {f[6:0], fl[`BOD_FLAG_C]};
                e.fval[`BOD_FLAG_C]  = f[7];
                e.fmask[`BOD_FLAG_C] = 1'b1;
            end
            `BOD_OP_RRC: begin
                e.res                = {fl[`BOD_FLAG_C], f[7:1]};
                e.fval[`BOD_FLAG_C]  = f[0];
                e.fmask[`BOD_FLAG_C] = 1'b1;
            end
            `BOD_OP_RLN: e.res = {f[6:0], f[7]};
            `BOD_OP_RRN: e.res = {f[0], f[7:1]};
            `BOD_OP_ZERO: begin
                e.res = 8'h00;
                e.wf  = 1'b1;
                e.wa  = ~op[8];
            end
            `BOD_OP_FILL: begin
                e.res = 8'hff;
                e.wf  = 1'b1;
                e.wa  = ~op[8];
            end
            `BOD_OP_NEG: begin
                ar    = add8(8'h00, ~a, 1'b1);
                arith = 1'b1;
                e.wf  = 1'b1;
                e.wa  = ~op[8];
            end
            `BOD_OP_DAW: begin
                s1 = {1'b0, a} + ((a[3:0] > 4'h9 || fl[`BOD_FLAG_DC]) ?
                                  9'h006 : 9'h000);
                s2 = s1 + ((s1[7:4] > 4'h9 || fl[`BOD_FLAG_C] || s1[8]) ?
                           9'h060 : 9'h000);
                e.res                = s2[7:0];
                e.fval[`BOD_FLAG_C]  = s2[8] | s1[8] | fl[`BOD_FLAG_C];
                e.fmask[`BOD_FLAG_C] = 1'b1;
                e.wf                 = 1'b1;
                e.wa                 = ~op[8];
            end
            default: begin
                // compares, multiply and bit operations write no accumulator
                e.wf = 1'b0;
                e.wa = 1'b0;
                case (op[15:8])
                    `BOD_OP_CPEQ: e.skip = (f == a);
                    `BOD_OP_CPGT: e.skip = (f > a);
                    `BOD_OP_CPLT: e.skip = (f < a);
                    `BOD_OP_MUL: begin
                        e.mul  = 1'b1;
                        e.prod = {8'h00, a} * {8'h00, f};
                    end
                    default: begin
                        // whole byte read, one bit changed, byte written back
                        e.wf = 1'b1;
                        case (op[15:11])
                            `BOD_OP_BCLR: e.res = f & ~bm;
                            `BOD_OP_BSET: e.res = f | bm;
                            `BOD_OP_BTOG: e.res = f ^ bm;
                            default:      e.wf  = 1'b0;
                        endcase
                    end
                endcase
            end
        endcase
        if (arith) begin
            e.res                 = ar[7:0];
            e.fval[`BOD_FLAG_C]   = ar[8];
            e.fval[`BOD_FLAG_DC]  = ar[9];
            e.fval[`BOD_FLAG_OV]  = ar[10];
            e.fmask[`BOD_FLAG_C]  = 1'b1;
            e.fmask[`BOD_FLAG_DC] = 1'b1;
            e.fmask[`BOD_FLAG_OV] = 1'b1;
            e.fmask[`BOD_FLAG_Z]  = 1'b1;
        end
        e.fval[`BOD_FLAG_Z] = (e.res == 8'h00);
        return e;
    endfunction

    // quarter-cycle sequencer, four clocks per instruction
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            q_phase_o <= BOD_Q1;
        end else begin
            case (q_phase_o)
                BOD_Q1:  q_phase_o <= BOD_Q2;
                BOD_Q2:  q_phase_o <= BOD_Q3;
                BOD_Q3:  q_phase_o <= BOD_Q4;
                BOD_Q4:  q_phase_o <= BOD_Q1;
                default: q_phase_o <= BOD_Q1;
            endcase
        end
    end

    // Q1 decode: take fetched word or force a nop, start operand read
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ir           <= `BOD_NOP;
            file_raddr_o <= 8'h00;
            file_rd_o    <= 1'b0;
        end else if (q_phase_o == BOD_Q1) begin
            ir           <= (skip_pend || !run) ? `BOD_NOP : instr_i;
            file_raddr_o <= (skip_pend || !run) ? 8'h00 : instr_i[7:0];
            file_rd_o    <= !(skip_pend || !run);
        end else begin
            file_rd_o    <= 1'b0;
        end
    end

    // operand source: internal registers shadow their file addresses
    always_comb begin
        opnd = file_rdata_i;
        if (ir[7:0] == `BOD_FADDR_PCL) begin
            opnd = pc_o[7:0];
        end else if (ir[7:0] == `BOD_FADDR_ALU) begin
            opnd = flags;
        end else if (ir[7:0] == `BOD_FADDR_ACC) begin
            opnd = acc;
        end
    end

    assign ex_now  = exec_op(ir, opnd, acc, flags);
    assign wr_pcl  = ex.wf && (ir[7:0] == `BOD_FADDR_PCL);
    assign wr_alu  = ex.wf && (ir[7:0] == `BOD_FADDR_ALU);
    assign wr_accf = ex.wf && (ir[7:0] == `BOD_FADDR_ACC);

    // Q3 process, file write request stands through Q4
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ex        <= '0;
            file_wr_o <= '0;
        end else if (q_phase_o == BOD_Q3) begin
            ex             <= ex_now;
            file_wr_o.we   <= ex_now.wf && (ir[7:0] != `BOD_FADDR_PCL) &&
                              (ir[7:0] != `BOD_FADDR_ALU) &&
                              (ir[7:0] != `BOD_FADDR_ACC);
            file_wr_o.addr <= ir[7:0];
            file_wr_o.data <= ex_now.res;
        end else if (q_phase_o == BOD_Q4) begin
            file_wr_o.we   <= 1'b0;
        end
    end

    // accumulator: core write in Q4 beats a bus write
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            acc <= 8'h00;
        end else if (q_phase_o == BOD_Q4 && (ex.wa || wr_accf)) begin
            acc <= ex.res;
        end else if (sw_we && avs_address_i == `BOD_REG_ACC) begin
            acc <= avs_writedata_i[7:0];
        end
    end

    // flag register: produced flags override written data
    always_comb begin
        next_flags = wr_alu ? ex.res : flags;
        next_flags = (next_flags & ~ex.fmask) | (ex.fval & ex.fmask);
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            flags <= 8'h00;
        end else if (q_phase_o == BOD_Q4) begin
            flags <= next_flags;
        end else if (sw_we && avs_address_i == `BOD_REG_FLAGS) begin
            flags <= avs_writedata_i[7:0];
        end
    end

    // program counter, high holding latch and skip
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pc_o      <= `BOD_PC_RST;
            latch     <= 8'h00;
            skip_pend <= 1'b0;
        end else begin
            // only a pure read refills the latch, writes must use it
            if (q_phase_o == BOD_Q2 && !ex_now.wf &&
                ir[7:0] == `BOD_FADDR_PCL) begin
                latch <= pc_o[15:8];
            end else if (sw_we && avs_address_i == `BOD_REG_LATCH) begin
                latch <= avs_writedata_i[7:0];
            end
            if (q_phase_o == BOD_Q4) begin
                pc_o      <= wr_pcl ? {latch, ex.res} : pc_o + 16'h0001;
                skip_pend <= ex.skip || wr_pcl;
            end
        end
    end

    // product register
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            prod <= 16'h0000;
        end else if (q_phase_o == BOD_Q4 && ex.mul) begin
            prod <= ex.prod;
        end
    end

    // hardware events land only in Q1; set wins over software clear
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            evt      <= 8'h00;
            evt_pend <= 8'h00;
        end else if (q_phase_o == BOD_Q1) begin
            evt      <= (evt & ~(sw_we && avs_address_i == `BOD_REG_EVENT ?
                         avs_writedata_i[7:0] : 8'h00)) |
                        evt_pend | hw_evt_i;
            evt_pend <= 8'h00;
        end else begin
            evt_pend <= evt_pend | hw_evt_i;
            if (sw_we && avs_address_i == `BOD_REG_EVENT) begin
                evt <= evt & ~avs_writedata_i[7:0];
            end
        end
    end

    // run control
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            run <= `BOD_CTRL_RST;
        end else if (sw_we && avs_address_i == `BOD_REG_CTRL) begin
            run <= avs_writedata_i[`BOD_CTRL_RUN];
        end
    end

    // register bus readback, unmapped reads return zero
    always_comb begin
        case (avs_address_i)
            `BOD_REG_CTRL:  rd_mux = {31'h0, run};
            `BOD_REG_ACC:   rd_mux = {24'h0, acc};
            `BOD_REG_FLAGS: rd_mux = {24'h0, flags};
            `BOD_REG_PC:    rd_mux = {16'h0, pc_o};
            `BOD_REG_LATCH: rd_mux = {24'h0, latch};
            `BOD_REG_EVENT: rd_mux = {24'h0, evt};
            `BOD_REG_PROD:  rd_mux = {16'h0, prod};
            default:        rd_mux = 32'h0;
        endcase
    end

    assign sw_we = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];

    // one wait cycle per request, then one accept cycle
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0;
        end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o    <= rd_mux;
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_q_four_phases: assert property (
        q_phase_o == BOD_Q1 |=> q_phase_o == BOD_Q2 ##1 q_phase_o == BOD_Q3
        ##1 q_phase_o == BOD_Q4 ##1 q_phase_o == BOD_Q1)
        else $error("quarter-cycle order broken");
    a_read_in_q2: assert property (
        file_rd_o |-> q_phase_o == BOD_Q2 && file_raddr_o == ir[7:0])
        else $error("file read outside Q2");
    a_write_in_q4: assert property (
        file_wr_o.we |-> q_phase_o == BOD_Q4)
        else $error("file write outside Q4");
    a_skip_forces_nop: assert property (
        q_phase_o == BOD_Q1 && skip_pend |=> ir == `BOD_NOP)
        else $error("skipped instruction not replaced");
    a_skip_taken: assert property (
        q_phase_o == BOD_Q4 && ex.skip |=> skip_pend ##1 ir == `BOD_NOP)
        else $error("true skip did not flush");
    a_no_false_skip: assert property (
        q_phase_o == BOD_Q4 && !ex.skip && !wr_pcl |=> !skip_pend)
        else $error("false skip inserted a nop");
    a_pcl_read_latch: assert property (
        q_phase_o == BOD_Q2 && !ex_now.wf && ir[7:0] == `BOD_FADDR_PCL
        |=> latch == $past(pc_o[15:8]))
        else $error("pc high not copied to latch");
    a_pcl_write_load: assert property (
        q_phase_o == BOD_Q4 && wr_pcl |=> pc_o == {$past(latch), $past(ex.res)})
        else $error("pc not loaded from latch");
    a_flag_override: assert property (
        q_phase_o == BOD_Q4 && wr_alu && ex.fmask[`BOD_FLAG_Z]
        |=> flags[`BOD_FLAG_Z] == $past(ex.res == 8'h00))
        else $error("zero flag lost on flag write");
    a_event_q1_only: assert property (
        evt != $past(evt) && (evt & ~$past(evt)) != 8'h00
        |-> $past(q_phase_o) == BOD_Q1)
        else $error("event bit set outside Q1");
    a_bus_answer: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus request not answered");

    c_skip_taken: cover property (q_phase_o == BOD_Q4 && ex.skip);
    c_pcl_write:  cover property (q_phase_o == BOD_Q4 && wr_pcl);
    c_multiply:   cover property (q_phase_o == BOD_Q4 && ex.mul);
    c_bus_read:   cover property (avs_read_i && !avs_waitrequest_o);

endmodule

`default_nettype wire

// *** rtl/bod_defs.svh ***
// constants for the byte-operation decode and execute core
// assumes inclusion by the core and the bench, guarded against repeats
`ifndef BOD_DEFS_SVH
`define BOD_DEFS_SVH

// register bus byte offsets
`define BOD_REG_CTRL     5'h00
`define BOD_REG_ACC      5'h04
`define BOD_REG_FLAGS    5'h08
`define BOD_REG_PC       5'h0c
`define BOD_REG_LATCH    5'h10
`define BOD_REG_EVENT    5'h14
`define BOD_REG_PROD     5'h18

// field positions
`define BOD_CTRL_RUN     0
`define BOD_FLAG_C       0
`define BOD_FLAG_DC      1
`define BOD_FLAG_Z       2
`define BOD_FLAG_OV      3

// reset values
`define BOD_CTRL_RST     1'b1
`define BOD_PC_RST       16'h0000
`define BOD_NOP          16'h0000

// file addresses served inside the core
`define BOD_FADDR_PCL    8'h01
`define BOD_FADDR_ALU    8'h02
`define BOD_FADDR_ACC    8'h03

// seven-bit opcodes carrying a destination or clear-select bit
`define BOD_OP_ADD       7'h07
`define BOD_OP_ADDC      7'h08
`define BOD_OP_SUB       7'h02
`define BOD_OP_SUBB      7'h01
`define BOD_OP_AND       7'h05
`define BOD_OP_OR        7'h04
`define BOD_OP_INV       7'h09
`define BOD_OP_DECSZ     7'h0b
`define BOD_OP_INCSZ     7'h0f
`define BOD_OP_DECSNZ    7'h13
`define BOD_OP_INCSNZ    7'h12
`define BOD_OP_RLC       7'h0d
`define BOD_OP_RRC       7'h0c
`define BOD_OP_RLN       7'h11
`define BOD_OP_RRN       7'h10
`define BOD_OP_ZERO      7'h14
`define BOD_OP_FILL      7'h15
`define BOD_OP_NEG       7'h16
`define BOD_OP_DAW       7'h17

// eight-bit opcodes
`define BOD_OP_CPLT      8'h30
`define BOD_OP_CPEQ      8'h31
`define BOD_OP_CPGT      8'h32
`define BOD_OP_MUL       8'h34

// five-bit bit-manipulation opcodes
`define BOD_OP_BCLR      5'h11
`define BOD_OP_BSET      5'h10
`define BOD_OP_BTOG      5'h07

`endif

// *** rtl/bod_pkg.sv ***
// types shared by the byte-operation decode and execute core
// needs nothing from the constants header
package bod_pkg;

    // quarter-cycle phase of an instruction cycle
    typedef enum logic [1:0] {BOD_Q1, BOD_Q2, BOD_Q3, BOD_Q4} bod_q_t;

    // result of executing one instruction
    typedef struct packed {
        logic [7:0]  res;
        logic        wf;
        logic        wa;
        logic [7:0]  fmask;
        logic [7:0]  fval;
        logic        skip;
        logic        mul;
        logic [15:0] prod;
    } bod_exec_t;

    // write request to the data file
    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] data;
    } bod_file_wr_t;

endpackage

// *** sim/bod_file_model.sv ***
// data file partner: 256 bytes, read data valid the cycle after strobe
// assumes the core strobes reads in Q2 and writes at the end of Q4
`timescale 1ns/10ps
`default_nettype none
module bod_file_model (
    input  wire logic                  core_clk_i,
    input  wire logic [7:0]            file_raddr_i,
    input  wire logic                  file_rd_i,
    input  wire bod_pkg::bod_file_wr_t file_wr_i,
    output logic      [7:0]            file_rdata_o
);
    import bod_pkg::*;
    logic [7:0] mem [256];
    initial file_rdata_o = 8'h00;
    // read on strobe, else scramble so stale data never passes
    always @(posedge core_clk_i) begin
        if (file_rd_i)
            file_rdata_o <= mem[file_raddr_i];
        else
            file_rdata_o <= ~file_rdata_o;
        if (file_wr_i.we)
            mem[file_wr_i.addr] <= file_wr_i.data;
    end
endmodule
`default_nettype wire

// *** sim/test_byte_op_decode_execute.sv ***
// self-checking bench for the decode and execute core
// assumes the file model partner and an avalon register map
`include "bod_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module test_byte_op_decode_execute;
    import bod_pkg::*;
    `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
    logic clk = 0, rst = 1, rd = 0, wr = 0;
    logic [15:0] instr = 16'h0000;
    logic [7:0] rdat, raddr, evt = 8'h00, a, f, fv;
    logic [4:0] addr = 5'h00;
    logic [31:0] wdat = 0, rq, q;
    logic frd, wt;
    logic [6:0] op;
    logic [3:0] fl = 4'h0;
    logic [11:0] ex;
    logic [15:0] pc;
    logic evt_on = 1'b1;
    logic [7:0] evt_force = 8'h00;
    // skip table on file 0x20: words, operands; taken for k 0, 2, 3, 4
    logic [15:0] sk [8] = '{16'h3120, 16'h3220, 16'h1720, 16'h1f20,
                            16'h2520, 16'h3020, 16'h2720, 16'h1720};
    logic [7:0] sr [8] = '{8'h40, 8'h40, 8'h01, 8'hff,
                           8'h40, 8'h41, 8'h01, 8'h40};
    logic [6:0] ops [11] = '{7'h07, 7'h08, 7'h02, 7'h01, 7'h05, 7'h04,
                             7'h09, 7'h0d, 7'h0c, 7'h11, 7'h10};
    bod_q_t qp;
    bod_file_wr_t fw;
    int bad_count = 0, comparisons = 0;
    bod_core DUT (.core_clk_i(clk), .sys_rst_i(rst), .instr_i(instr),
        .q_phase_o(qp), .pc_o(pc), .file_raddr_o(raddr), .file_rd_o(frd),
        .file_rdata_i(rdat), .file_wr_o(fw), .hw_evt_i(evt),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rq), .avs_waitrequest_o(wt));
    bod_file_model m (.core_clk_i(clk), .file_raddr_i(raddr),
        .file_rd_i(frd), .file_wr_i(fw), .file_rdata_o(rdat));
    // clock and random event traffic
    initial forever #10 clk = ~clk;
    always @(posedge clk)
        evt <= (evt_on ? 8'($urandom) & 8'h11 : 8'h00) | evt_force;
    // avalon access held until waitrequest seen low
    task automatic bus(input logic w, input logic [4:0] ad,
                       input logic [31:0] d, output logic [31:0] o);
        @(posedge clk);
        addr <= ad; wr <= w; rd <= !w; wdat <= d;
        do @(posedge clk); while (wt !== 1'b0);
        o = rq;
        wr <= 0; rd <= 0;
    endtask
    // issue a word in a Q1 cycle and a second one right behind it
    task automatic exec(input logic [15:0] w,
                        input logic [15:0] nx = 16'h0000);
        do @(posedge clk); while (qp !== BOD_Q4);
        instr <= w;
        repeat (4) @(posedge clk);
        instr <= nx;
        repeat (4) @(posedge clk);
        instr <= 16'h0000;
    endtask
    // expected result and flags {res, OV Z DC C}
    function automatic logic [11:0] ref_op(input logic [6:0] o,
        input logic [7:0] fo, ac, input logic [3:0] fi);
        logic [8:0] s; logic [4:0] h; logic [7:0] y; logic c;
        logic [3:0] n;
        n = fi; y = ac; c = 0;
        if (o == `BOD_OP_SUB || o == `BOD_OP_SUBB) y = ~ac;
        if (o == `BOD_OP_SUB) c = 1;
        if (o == `BOD_OP_SUBB || o == `BOD_OP_ADDC) c = fi[0];
        s = fo + y + c;
        h = fo[3:0] + y[3:0] + c;
        n[2] = 0;
        case (o)
            `BOD_OP_AND: s[7:0] = fo & ac;
            `BOD_OP_OR:  s[7:0] = fo | ac;
            `BOD_OP_INV: s[7:0] = ~fo;
            `BOD_OP_RLC: {n[0], s[7:0]} = {fo, fi[0]};
            `BOD_OP_RRC: {s[7:0], n[0]} = {fi[0], fo};
            `BOD_OP_RLN: return {fo[6:0], fo[7], fi};
            `BOD_OP_RRN: return {fo[0], fo[7:1], fi};
            default: begin
                n = {(fo[7] == y[7]) && (s[7] != fo[7]), 1'b0, h[4], s[8]};
            end
        endcase
        if (o != `BOD_OP_RLC && o != `BOD_OP_RRC) n[2] = (s[7:0] == 0);
        else n[2] = fi[2];
        return {s[7:0], n};
    endfunction
    task automatic results;
        $display("comparisons %0d errors %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #(20 * 40000);
        bad_count++;
        results();
    end
    initial begin
        void'($urandom(31470));
        repeat (12) @(posedge clk);
        rst <= 0;
        // random arithmetic, logic and rotates, both destinations
        for (int i = 0; i < 60; i++) begin
            op = ops[$urandom % 11]; f = 8'($urandom % 200 + 16);
            a = 8'($urandom); fv = i < 2 ? a : 8'($urandom);
            m.mem[f] = fv;
            bus(1, `BOD_REG_ACC, {24'h0, a}, q);
            exec({op, i[0], f});
            ex = ref_op(op, fv, a, fl);
            fl = ex[3:0];
            bus(0, `BOD_REG_ACC, 0, q);
            `CHK(q[7:0], i[0] ? a : ex[11:4])
            `CHK(m.mem[f], i[0] ? ex[11:4] : fv)
            bus(0, `BOD_REG_FLAGS, 0, q);
            `CHK(q[3:0], fl)
        end
        // skip table: compares and counting skips, a clear right behind
        for (int k = 0; k < 8; k++) begin
            m.mem[8'h20] = sr[k]; m.mem[8'h21] = 8'h5a;
            bus(1, `BOD_REG_ACC, 32'h40, q);
            exec(sk[k], {`BOD_OP_ZERO, 1'b1, 8'h21});
            bus(0, `BOD_REG_FLAGS, 0, q);
            `CHK(q[3:0], fl)
            `CHK(m.mem[8'h21], k inside {0, 2, 3, 4} ? 8'h5a : 8'h00)
        end
        // multiply, bit set, negate, fill and a stopped core
        a = 8'($urandom); fv = 8'($urandom); m.mem[8'h23] = fv;
        m.mem[8'h24] = 8'h0f; m.mem[8'h25] = 8'h00;
        bus(1, `BOD_REG_ACC, {24'h0, a}, q);
        exec({`BOD_OP_MUL, 8'h23});
        exec({`BOD_OP_BSET, 3'd5, 8'h24});
        bus(0, `BOD_REG_PROD, 0, q);
        `CHK(q[15:0], 16'(a) * 16'(fv))
        `CHK(m.mem[8'h24], 8'h2f)
        exec({`BOD_OP_NEG, 1'b0, 8'h22});
        ex = ref_op(`BOD_OP_SUB, 8'h00, a, fl);
        fl = ex[3:0];
        bus(0, `BOD_REG_ACC, 0, q);
        `CHK(q[7:0], ex[11:4])
        `CHK(m.mem[8'h22], ex[11:4])
        bus(0, `BOD_REG_FLAGS, 0, q);
        `CHK(q[3:0], fl)
        bus(1, `BOD_REG_CTRL, 0, q);
        exec({`BOD_OP_FILL, 1'b0, 8'h25});
        bus(1, `BOD_REG_CTRL, 1, q);
        `CHK(m.mem[8'h25], 8'h00)
        exec({`BOD_OP_FILL, 1'b0, 8'h25});
        bus(0, `BOD_REG_ACC, 0, q);
        `CHK(q[7:0], 8'hff)
        `CHK(m.mem[8'h25], 8'hff)
        // pc low write takes the latch, a pc low read refills it
        bus(1, `BOD_REG_LATCH, 32'h5c, q);
        exec({`BOD_OP_ZERO, 1'b1, `BOD_FADDR_PCL});
        bus(1, `BOD_REG_LATCH, 0, q);
        exec({`BOD_OP_CPEQ, `BOD_FADDR_PCL});
        bus(0, `BOD_REG_LATCH, 0, q);
        `CHK(pc[15:8], 8'h5c)
        `CHK(q[7:0], 8'h5c)
        // events: clear all, then one pulse lands at a Q1 edge
        evt_on <= 1'b0;
        repeat (8) @(posedge clk);
        bus(1, `BOD_REG_EVENT, 32'hff, q);
        bus(0, `BOD_REG_EVENT, 0, q);
        `CHK(q[7:0], 8'h00)
        evt_force <= 8'h04;
        @(posedge clk);
        evt_force <= 8'h00;
        repeat (8) @(posedge clk);
        bus(0, `BOD_REG_EVENT, 0, q);
        `CHK(q[7:0], 8'h04)
        results();
    end
endmodule
`default_nettype wire
